// >>> src/tmp_pins_pkg.sv
// Package for the port pin block: widths, reset values and carriers
package tmp_pins_pkg;
    // Port widths and synchroniser depth
    localparam int PA_BIDIR_W = 3;
    localparam int PB_W = 8;
    localparam int PD_W = 8;
    localparam int SYNC_STAGES = 2;
    // Bit positions of the bidirectional port A pins inside a 3-bit group
    localparam int PA_BIT0 = 0;
    localparam int PA_BIT1 = 1;
    localparam int PA_BIT3 = 2;
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] RST_TRIO = 3'h0;
    localparam logic RST_BIT = 1'h0;

    // Port A configuration from the core
    typedef struct packed {
        logic ledOn;                   // Sink current on the LED pin
        logic [2:0] dir;               // 1 = output, order pin3, pin1, pin0
        logic [2:0] data;              // Output level
        logic [2:0] pullSel;           // Pull-up selection per bit
    } tmp_porta_cfg_t;

    // Port B configuration from the core
    typedef struct packed {
        logic pullAll;                 // Common pull-up selection
        logic [7:0] altEn;             // Alternate function owns the pin
    } tmp_portb_cfg_t;

    // Port D configuration from the core
    typedef struct packed {
        logic [7:0] dir;               // 1 = output
        logic [7:0] data;              // Output level
        logic [7:0] pullSel;           // Pull-up selection per bit
    } tmp_portd_cfg_t;

    // Drive bundle for a group of pins
    typedef struct packed {
        logic [7:0] out;               // Driven level
        logic [7:0] oe;                // High while driving
        logic [7:0] pullEn;            // Pull-up switched in
    } tmp_pin_drive_t;
endpackage

// >>> src/tmp_port_pins.sv
// Pin-level logic of the three general-purpose ports
//
// Contract
// - Port A pin 2 output-only LED sink
// - Port A pins 3,1,0 bidirectional, own pull-ups
// - Port B eight inputs, one shared pull-up select
// - Alternate function use disables that pin's pull-up
// - Any reset floats all pins; only the external pin does so clockless
// - Port D eight bidirectional pins, own pull-ups
// - Low external reset pin forces the pin drives into reset asynchronously
`timescale 1ns/10ps
`default_nettype none
module tmp_port_pins
    import tmp_pins_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk,
    input wire logic reset,
    input wire logic clkEn,
    // External active-low reset pin
    input wire logic extResetN,
    // Configuration from the core
    input wire tmp_porta_cfg_t cfgA,
    input wire tmp_portb_cfg_t cfgB,
    input wire tmp_portd_cfg_t cfgD,
    // LED sink pin, output only
    output logic ledSinkOut,
    output logic ledSinkOe,
    // Port A bidirectional pins (pin3, pin1, pin0)
    input wire logic [2:0] portaPinIn,
    output tmp_pin_drive_t portaDrive,
    // Port B input pins
    input wire logic [7:0] inputPortPinsIn,
    output logic [7:0] inputPortPullEn,
    // Port D bidirectional pins
    input wire logic [7:0] bidirPortPinsIn,
    output tmp_pin_drive_t bidirPortDrive,
    // Synchronised pin levels for the core
    output logic [2:0] portaRead,
    output logic [7:0] inputPortRead,
    output logic [7:0] bidirPortRead,
    // Reset seen on the external pin, synchronised
    output logic extResetSeen
);

    // Pull-up gating shared by the two bidirectional ports
    function automatic logic [7:0] pullCalc(input logic [7:0] sel,
                                            input logic [7:0] dir);
        pullCalc = sel & ~dir;
    endfunction

    // Registered pin drives
    logic ledOut_reg;
    logic ledOe_reg;
    tmp_pin_drive_t aDrive_reg;
    logic [7:0] bPull_reg;
    tmp_pin_drive_t dDrive_reg;
    // Synchroniser stages; stage 0 is read only by stage 1
    logic [2:0] aSync0_reg;
    logic [2:0] aSync1_reg;
    logic [7:0] bSync0_reg;
    logic [7:0] bSync1_reg;
    logic [7:0] dSync0_reg;
    logic [7:0] dSync1_reg;
    logic rstSync0_reg;
    logic rstSync1_reg;
    // Next values
    tmp_pin_drive_t aDrive_next;
    tmp_pin_drive_t dDrive_next;
    logic [7:0] bPull_next;

    // Next drive values from the configuration
    always_comb begin
        aDrive_next = '0;
        aDrive_next.out[2:0] = cfgA.data;
        aDrive_next.oe[2:0] = cfgA.dir;
        aDrive_next.pullEn = pullCalc({5'h00, cfgA.pullSel},
                                      {5'h00, cfgA.dir});
        dDrive_next.out = cfgD.data;
        dDrive_next.oe = cfgD.dir;
        dDrive_next.pullEn = pullCalc(cfgD.pullSel, cfgD.dir);
        // Shared selection, but an alternate function wins per pin
        bPull_next = {PB_W{cfgB.pullAll}} & ~cfgB.altEn;
    end

    // Pin drives: the external pin clears them with no clock at all,
    // so a stopped oscillator cannot leave a pin driven during reset
    always_ff @(posedge clk or negedge extResetN) begin
        if (!extResetN) begin
            ledOut_reg <= RST_BIT;
            ledOe_reg <= RST_BIT;
            aDrive_reg <= '0;
            bPull_reg <= RST_BYTE;
            dDrive_reg <= '0;
        end else if (reset) begin
            // Internal reset sources float the pins too
            ledOut_reg <= RST_BIT;
            ledOe_reg <= RST_BIT;
            aDrive_reg <= '0;
            bPull_reg <= RST_BYTE;
            dDrive_reg <= '0;
        end else if (clkEn) begin
            // Sink only: the pin is pulled low when lit, never read
            ledOut_reg <= RST_BIT;
            ledOe_reg <= cfgA.ledOn;
            aDrive_reg <= aDrive_next;
            bPull_reg <= bPull_next;
            dDrive_reg <= dDrive_next;
        end
    end

    // Two-stage synchronisers for pin levels; no LED pin input exists
    always_ff @(posedge clk) begin
        if (reset) begin
            aSync0_reg <= RST_TRIO;
            aSync1_reg <= RST_TRIO;
            bSync0_reg <= RST_BYTE;
            bSync1_reg <= RST_BYTE;
            dSync0_reg <= RST_BYTE;
            dSync1_reg <= RST_BYTE;
        end else if (clkEn) begin
            aSync0_reg <= portaPinIn;
            aSync1_reg <= aSync0_reg;
            bSync0_reg <= inputPortPinsIn;
            bSync1_reg <= bSync0_reg;
            dSync0_reg <= bidirPortPinsIn;
            dSync1_reg <= dSync0_reg;
        end
    end

    // External reset level, synchronised for the core's reset logic
    always_ff @(posedge clk) begin
        if (reset) begin
            rstSync0_reg <= RST_BIT;
            rstSync1_reg <= RST_BIT;
        end else if (clkEn) begin
            rstSync0_reg <= ~extResetN;
            rstSync1_reg <= rstSync0_reg;
        end
    end

    // Outputs come straight from the flip-flops
    assign ledSinkOut = ledOut_reg;
    assign ledSinkOe = ledOe_reg;
    assign portaDrive = aDrive_reg;
    assign inputPortPullEn = bPull_reg;
    assign bidirPortDrive = dDrive_reg;
    assign portaRead = aSync1_reg;
    assign inputPortRead = bSync1_reg;
    assign bidirPortRead = dSync1_reg;
    assign extResetSeen = rstSync1_reg;

    // Checks, all on the core clock
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // One enabled cycle with the external pin released, then one more cycle with it still released
    sequence s_live_step;
        clkEn && extResetN ##1 extResetN;
    endsequence

    // External reset pin released for two enabled cycles, then a third edge
    sequence s_d_steady;
        (clkEn && extResetN) [*2] ##1 1'b1;
    endsequence

    // Low reset pin: nothing driven, nothing pulled
    a_ext_float_all: assert property (
        !extResetN |-> (ledSinkOe == 1'b0) && (portaDrive == '0)
            && (bidirPortDrive == '0) && (inputPortPullEn == 8'h00))
        else $error("pins driven while external reset is low");

    // LED pin sinks when lit and never drives high
    a_led_sink_follows: assert property (
        s_live_step
            |-> ledSinkOe == $past(cfgA.ledOn) && ledSinkOut == 1'b0)
        else $error("LED sink pin does not follow its enable");

    // Port A drive follows one enabled edge behind
    a_porta_dir_out: assert property (
        s_live_step |-> portaDrive.oe[2:0] == $past(cfgA.dir)
            && portaDrive.out[2:0] == $past(cfgA.data))
        else $error("port A drive does not follow direction and data");

    // One shared select, masked per pin by alternate use
    a_portb_common_pull: assert property (
        s_live_step |-> inputPortPullEn ==
            ({8{$past(cfgB.pullAll)}} & ~$past(cfgB.altEn)))
        else $error("port B pull-up not shared or not overridden");

    a_portb_alt_off: assert property (
        s_live_step |-> (inputPortPullEn & $past(cfgB.altEn)) == 8'h00)
        else $error("pull-up left on under an alternate function");

    // Pull-up and output drive never meet on one pin
    a_pull_only_input: assert property (
        (bidirPortDrive.pullEn & bidirPortDrive.oe) == 8'h00
            && (portaDrive.pullEn & portaDrive.oe) == 8'h00)
        else $error("pull-up active on a pin driven as output");

    a_portd_pull_sel: assert property (
        s_live_step |-> bidirPortDrive.pullEn ==
            ($past(cfgD.pullSel) & ~$past(cfgD.dir))
            && bidirPortDrive.oe == $past(cfgD.dir))
        else $error("port D pull-up or direction wrong");

    // Read-back lags the pin by exactly two enabled edges
    a_portd_read_lat: assert property (
        (clkEn && extResetN) ##0 s_d_steady |->
            bidirPortRead == $past(bidirPortPinsIn, 2))
        else $error("port D read-back latency is not two cycles");

    // Enable low: every drive and pull holds its last value
    a_freeze_hold: assert property (
        !clkEn && extResetN ##1 extResetN |-> $stable(portaDrive)
            && $stable(bidirPortDrive) && $stable(inputPortPullEn)
            && $stable(ledSinkOe))
        else $error("drive changed while the clock enable was low");

    a_unused_float: assert property (
        portaDrive.oe[7:3] == 5'h00 && portaDrive.pullEn[7:3] == 5'h00)
        else $error("nonexistent port A bits driven");

endmodule
`default_nettype wire

// >>> testbench/tmp_board.sv
// Board model: resolves port pin levels from device drives and outside parts
`timescale 1ns/10ps
`default_nettype none
module tmp_board
    import tmp_pins_pkg::*;
(
    // Clock
    input wire logic clk,
    // Device side
    input wire tmp_pin_drive_t aDrive,
    input wire logic [7:0] bPull,
    input wire tmp_pin_drive_t dDrive,
    // Outside drivers, order A(3) B(8) D(8)
    input wire logic [18:0] extEn,
    input wire logic [18:0] extVal,
    // Resolved levels
    output logic [18:0] pins
);
    // Floating level toggles, so a stale value never passes for a real one
    logic flt = 1'b0;
    logic [18:0] oe, lvl, pu;
    always @(posedge clk) flt <= ~flt;
    // Device drive wins, then outside driver, then pull-up, else float
    always_comb begin
        oe = {aDrive.oe[2:0], 8'h00, dDrive.oe}; // Port B never driven
        lvl = {aDrive.out[2:0], 8'h00, dDrive.out};
        pu = {aDrive.pullEn[2:0], bPull, dDrive.pullEn};
        for (int i = 0; i < 19; i++) begin
            pins[i] = oe[i] ? lvl[i] : extEn[i] ? extVal[i] :
                      pu[i] ? 1'b1 : flt ^ i[0];
        end
    end
endmodule
`default_nettype wire

// >>> testbench/test_tmp_port_pins.sv
// Self-checking bench for the port pin block
`timescale 1ns/10ps
`default_nettype none
module test_tmp_port_pins;
    import tmp_pins_pkg::*;
    // Stimulus
    logic clk = 1'b0, run = 1'b1, reset = 1'b1, clkEn = 1'b0;
    logic extResetN = 1'b1, rdOk = 1'b1;
    tmp_porta_cfg_t cfgA = '0;
    tmp_portb_cfg_t cfgB = '0;
    tmp_portd_cfg_t cfgD = '0;
    logic [18:0] extEn = '0, extVal = '0, pins;
    // Design outputs
    logic ledSinkOut, ledSinkOe, extResetSeen;
    tmp_pin_drive_t portaDrive, bidirPortDrive;
    logic [7:0] inputPortPullEn, inputPortRead, bidirPortRead;
    logic [2:0] portaRead;
    // Reference model state
    tmp_pin_drive_t eA, eD;
    logic [7:0] eB;
    logic eLed, x0, x1;
    logic [18:0] s0, s1;
    int errorCnt = 0, nCompared = 0;

    // Clock can be stopped to show reset acting without it
    always #5 if (run) clk = ~clk;

    tmp_port_pins u_dut (.clk(clk), .reset(reset), .clkEn(clkEn),
        .extResetN(extResetN), .cfgA(cfgA), .cfgB(cfgB), .cfgD(cfgD),
        .ledSinkOut(ledSinkOut), .ledSinkOe(ledSinkOe),
        .portaPinIn(pins[18:16]), .portaDrive(portaDrive),
        .inputPortPinsIn(pins[15:8]), .inputPortPullEn(inputPortPullEn),
        .bidirPortPinsIn(pins[7:0]), .bidirPortDrive(bidirPortDrive),
        .portaRead(portaRead), .inputPortRead(inputPortRead),
        .bidirPortRead(bidirPortRead), .extResetSeen(extResetSeen));

    tmp_board u_board (.clk(clk), .aDrive(portaDrive),
        .bPull(inputPortPullEn), .dDrive(bidirPortDrive), .extEn(extEn),
        .extVal(extVal), .pins(pins));

    // Expected drives; the external pin clears them with no clock
    always @(posedge clk or negedge extResetN) begin
        if (!extResetN || reset) begin
            eA <= '0;
            eD <= '0;
            eB <= '0;
            eLed <= 1'b0;
        end else if (clkEn) begin
            eLed <= cfgA.ledOn;
            eA <= {5'h00, cfgA.data, 5'h00, cfgA.dir,
                   5'h00, cfgA.pullSel & ~cfgA.dir};
            eB <= {8{cfgB.pullAll}} & ~cfgB.altEn;
            eD <= {cfgD.data, cfgD.dir, cfgD.pullSel & ~cfgD.dir};
        end
    end
    // Expected two-stage read and reset-seen chains
    always @(posedge clk) begin
        if (reset) begin
            {s0, s1, x0, x1} <= '0;
        end else if (clkEn) begin
            s0 <= pins;
            s1 <= s0;
            x0 <= !extResetN;
            x1 <= x0;
        end
    end

    task automatic chk(input string nm, input logic [23:0] seen, exp);
        nCompared++;
        if (seen !== exp) begin
            errorCnt++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Every output against the model; out only matters where driven
    task automatic checkAll;
        chk("ledOe", ledSinkOe, eLed);
        chk("ledOut", ledSinkOut, 1'b0);
        chk("aOe", portaDrive.oe, eA.oe);
        chk("aOut", portaDrive.out & portaDrive.oe, eA.out & eA.oe);
        chk("aPull", portaDrive.pullEn, eA.pullEn);
        chk("bPull", inputPortPullEn, eB);
        chk("dOe", bidirPortDrive.oe, eD.oe);
        chk("dOut", bidirPortDrive.out & bidirPortDrive.oe,
            eD.out & eD.oe);
        chk("dPull", bidirPortDrive.pullEn, eD.pullEn);
        chk("rstSeen", extResetSeen, x1);
        if (rdOk) chk("reads", {portaRead, inputPortRead, bidirPortRead},
            s1);
    endtask

    task automatic finalReport;
        if (errorCnt == 0 && nCompared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Watchdog: the whole run takes well under 6 us
    initial begin
        #20000;
        errorCnt++;
        finalReport();
    end

    initial begin
        void'($urandom(20));
        repeat (20) @(negedge clk);
        reset = 1'b0;
        // Random configs, stalls, reset pulses and outside drivers
        for (int k = 0; k < 400; k++) begin
            @(negedge clk);
            checkAll();
            cfgA = 10'($urandom);
            cfgB = 9'($urandom);
            cfgD = 24'($urandom);
            clkEn = ($urandom % 4) != 0;
            reset = ($urandom % 32) == 0;
            extEn = 19'($urandom);
            extVal = 19'($urandom);
        end
        // Every pin driven or pulled, then external reset, clock stopped
        @(negedge clk);
        {reset, clkEn} = 2'b01;
        cfgA = '1;
        cfgB = {1'b1, 8'h00};
        cfgD = {8'hFF, 8'h0F, 8'hFF};
        @(negedge clk);
        checkAll();
        rdOk = 1'b0;
        run = 1'b0;
        #3 extResetN = 1'b0;
        #20 checkAll();
        run = 1'b1;
        repeat (4) @(negedge clk) checkAll();
        extResetN = 1'b1;
        repeat (4) @(negedge clk) checkAll();
        rdOk = 1'b1;
        repeat (4) @(negedge clk) checkAll();
        finalReport();
    end
endmodule
`default_nettype wire
